// >>> inc/ptg_map.svh
`ifndef PTG_MAP_SVH
`define PTG_MAP_SVH

// ==========================================================
// register offsets (byte addresses, one aligned word each)
`define CONTROL_OFS          12'h000
`define STATUS_OFS           12'h004
`define ADJUST_OFS           12'h008
`define HOLD_OFS             12'h00c
`define LOOP_LIMIT_0_OFS     12'h010
`define LOOP_LIMIT_1_OFS     12'h014
`define TIMER_LIMIT_0_OFS    12'h018
`define TIMER_LIMIT_1_OFS    12'h01c
`define STEP_DELAY_LIMIT_OFS 12'h020
`define LITERAL_OFS          12'h024
`define BROADCAST_OFS        12'h028
`define QUEUE_POINTER_OFS    12'h02c
`define LOOP_COUNTER_0_OFS   12'h030
`define LOOP_COUNTER_1_OFS   12'h034
// queue words sit at 0x040..0x05c, selected by address bits 11:5
`define QUEUE_SEL            7'h02

// ==========================================================
// control and status bits
`define CTRL_RUN_BIT   0
`define CTRL_SWT_BIT   1
`define STAT_RUN_BIT   0
`define STAT_WAIT_BIT  1
`define STAT_DELAY_BIT 2

// ==========================================================
// operation codes (upper nibble of a step byte)
`define OP_CONTROL   4'h0
`define OP_ADD_COPY  4'h1
`define OP_STROBE_0  4'h2
`define OP_STROBE_1  4'h3
`define OP_WAIT_RISE 4'h4
`define OP_WAIT_FALL 4'h5
`define OP_IRQ       4'h7
`define OP_TRIG_0    4'h8
`define OP_TRIG_1    4'h9
`define OP_JUMP_0    4'ha
`define OP_JUMP_1    4'hb
`define OP_LOOP0_0   4'hc
`define OP_LOOP0_1   4'hd
`define OP_LOOP1_0   4'he
`define OP_LOOP1_1   4'hf

// ==========================================================
// control options
`define CTL_NOP      4'h0
`define CTL_SD_OFF   4'h2
`define CTL_SD_ON    4'h6
`define CTL_TMR0     4'h8
`define CTL_TMR1     4'h9
`define CTL_SWT_LVL  4'ha
`define CTL_SWT_EDGE 4'hb
`define CTL_STB_C0   4'hc
`define CTL_STB_C1   4'hd
`define CTL_STB_LIT  4'he
`define CTL_BCAST    4'hf

// ==========================================================
// limit file indices, shared by add and copy targets
`define LIM_LOOP0 3'h0
`define LIM_LOOP1 3'h1
`define LIM_TMR0  3'h2
`define LIM_TMR1  3'h3
`define LIM_SD    3'h4
`define LIM_LIT   3'h5
`define LIM_COUNT 6

`endif

// >>> inc/ptg_pkg.sv
package ptg_pkg;
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] opt;
  } step_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_WAIT,
    ST_DELAY
  } seq_state_t;
endpackage

// >>> core/trigger_sequencer_step_decoder.sv
`include "ptg_map.svh"

module trigger_sequencer_step_decoder
  import ptg_pkg::*;
#(
  parameter int DW    = 16,
  parameter int N_IN  = 16,
  parameter int N_OUT = 32,
  parameter int N_IRQ = 8
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  input  wire logic [3:0]       PSTRB,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic [N_IN-1:0]  TRIG_IN,
  output logic      [N_OUT-1:0] TRIG_OUT,
  output logic      [N_IRQ-1:0] IRQ,
  output logic      [DW-1:0]    STROBE,
  output logic                  STROBE_VALID,
  output logic                  RUNNING
);

  // ==========================================================
  // state
  seq_state_t       state;
  logic [7:0]       queue [0:31];
  logic [4:0]       queue_pointer;
  logic [4:0]       pend_ptr;
  step_t            cur_step;
  logic [DW-1:0]    lim [0:`LIM_COUNT-1];
  logic [DW-1:0]    adjust_value;
  logic [DW-1:0]    hold_value;
  logic [N_OUT-1:0] broadcast_trigger_enable;
  logic [DW-1:0]    loop_counter_0;
  logic [DW-1:0]    loop_counter_1;
  logic [DW-1:0]    timer;
  logic [DW-1:0]    delay_cnt;
  logic             step_delay_timer;
  logic             run;
  logic             software_trigger_bit;
  logic             swt_prev;
  logic [N_IN-1:0]  trig_prev;

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      `CONTROL_OFS, `STATUS_OFS, `ADJUST_OFS, `HOLD_OFS,
      `LOOP_LIMIT_0_OFS, `LOOP_LIMIT_1_OFS, `TIMER_LIMIT_0_OFS,
      `TIMER_LIMIT_1_OFS, `STEP_DELAY_LIMIT_OFS, `LITERAL_OFS,
      `BROADCAST_OFS, `QUEUE_POINTER_OFS, `LOOP_COUNTER_0_OFS,
      `LOOP_COUNTER_1_OFS: addr_known = 1'b1;
      default: addr_known = (a[11:5] == `QUEUE_SEL) && (a[1:0] == 2'b00);
    endcase
  endfunction

  // ==========================================================
  // apb slave: one wait state, write lands on the pready edge
  logic wr;
  logic idle;
  logic [31:0] rd_mux;
  assign wr   = PSEL && PENABLE && PREADY && PWRITE;
  assign idle = (state == ST_IDLE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `CONTROL_OFS: begin
        rd_mux[`CTRL_RUN_BIT] = run;
        rd_mux[`CTRL_SWT_BIT] = software_trigger_bit;
      end
      `STATUS_OFS: begin
        rd_mux[`STAT_RUN_BIT]   = !idle;
        rd_mux[`STAT_WAIT_BIT]  = (state == ST_WAIT);
        rd_mux[`STAT_DELAY_BIT] = step_delay_timer;
      end
      `ADJUST_OFS:           rd_mux[DW-1:0] = adjust_value;
      `HOLD_OFS:             rd_mux[DW-1:0] = hold_value;
      `LOOP_LIMIT_0_OFS:     rd_mux[DW-1:0] = lim[`LIM_LOOP0];
      `LOOP_LIMIT_1_OFS:     rd_mux[DW-1:0] = lim[`LIM_LOOP1];
      `TIMER_LIMIT_0_OFS:    rd_mux[DW-1:0] = lim[`LIM_TMR0];
      `TIMER_LIMIT_1_OFS:    rd_mux[DW-1:0] = lim[`LIM_TMR1];
      `STEP_DELAY_LIMIT_OFS: rd_mux[DW-1:0] = lim[`LIM_SD];
      `LITERAL_OFS:          rd_mux[DW-1:0] = lim[`LIM_LIT];
      `BROADCAST_OFS:        rd_mux[N_OUT-1:0] = broadcast_trigger_enable;
      `QUEUE_POINTER_OFS:    rd_mux[4:0] = queue_pointer;
      `LOOP_COUNTER_0_OFS:   rd_mux[DW-1:0] = loop_counter_0;
      `LOOP_COUNTER_1_OFS:   rd_mux[DW-1:0] = loop_counter_1;
      default: begin
        if (PADDR[11:5] == `QUEUE_SEL) begin
          rd_mux = {queue[{PADDR[4:2], 2'd3}], queue[{PADDR[4:2], 2'd2}],
                    queue[{PADDR[4:2], 2'd1}], queue[{PADDR[4:2], 2'd0}]};
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= !addr_known(PADDR);
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // control register stays writable so software can stop a running queue
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      run                  <= 1'b0;
      software_trigger_bit <= 1'b0;
    end else if (wr && PADDR == `CONTROL_OFS) begin
      run                  <= PWDATA[`CTRL_RUN_BIT];
      software_trigger_bit <= PWDATA[`CTRL_SWT_BIT];
    end
  end

  // ==========================================================
  // step decode
  step_t active;
  logic  is_exec;
  logic  lp_sel;
  logic  lp_equal;
  logic  wait_done;
  logic  waits;
  logic  step_done;
  logic  go_delay;
  logic  advance;
  logic [4:0] target;
  logic [4:0] next_ptr;
  logic [4:0] adv_ptr;

  // a stop cancels the step in hand, so unless stopped in its step delay it is not fired twice on resume
  assign is_exec = (state == ST_EXEC) && run;
  assign active  = is_exec ? step_t'(queue[queue_pointer]) : cur_step;
  assign target  = {active.op[0], active.opt};
  assign lp_sel  = active.op[1];
  assign lp_equal = lp_sel ? (loop_counter_1 == lim[`LIM_LOOP1])
                           : (loop_counter_0 == lim[`LIM_LOOP0]);

  always_comb begin
    waits    = 1'b0;
    next_ptr = queue_pointer + 5'd1;
    case (active.op)
      `OP_CONTROL: begin
        case (active.opt)
          `CTL_TMR0, `CTL_TMR1, `CTL_SWT_LVL, `CTL_SWT_EDGE: waits = 1'b1;
          default: waits = 1'b0;
        endcase
      end
      `OP_WAIT_RISE, `OP_WAIT_FALL: waits = 1'b1;
      `OP_JUMP_0, `OP_JUMP_1: next_ptr = target;
      `OP_LOOP0_0, `OP_LOOP0_1, `OP_LOOP1_0, `OP_LOOP1_1: begin
        if (!lp_equal) begin
          next_ptr = target;
        end
      end
      default: waits = 1'b0;
    endcase
  end

  always_comb begin
    wait_done = 1'b0;
    case (cur_step.op)
      `OP_WAIT_RISE: wait_done = TRIG_IN[cur_step.opt] && !trig_prev[cur_step.opt];
      `OP_WAIT_FALL: wait_done = !TRIG_IN[cur_step.opt] && trig_prev[cur_step.opt];
      `OP_CONTROL: begin
        case (cur_step.opt)
          `CTL_TMR0:     wait_done = (timer == lim[`LIM_TMR0]);
          `CTL_TMR1:     wait_done = (timer == lim[`LIM_TMR1]);
          `CTL_SWT_LVL:  wait_done = software_trigger_bit;
          `CTL_SWT_EDGE: wait_done = software_trigger_bit && !swt_prev;
          default:       wait_done = 1'b1;
        endcase
      end
      default: wait_done = 1'b1;
    endcase
  end

  assign step_done = (is_exec && !waits) || (state == ST_WAIT && wait_done);
  assign go_delay  = step_delay_timer && (lim[`LIM_SD] != '0);
  assign advance   = run && ((step_done && !go_delay) ||
                     (state == ST_DELAY && delay_cnt == lim[`LIM_SD]));
  assign adv_ptr   = is_exec ? next_ptr : pend_ptr;

  // ==========================================================
  // sequencer state
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else if (!run) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_EXEC;
        ST_EXEC: begin
          if (waits) begin
            state <= ST_WAIT;
          end else if (go_delay) begin
            state <= ST_DELAY;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state <= go_delay ? ST_DELAY : ST_EXEC;
          end
        end
        ST_DELAY: begin
          if (delay_cnt == lim[`LIM_SD]) begin
            state <= ST_EXEC;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cur_step <= '0;
      pend_ptr <= 5'h00;
    end else if (is_exec) begin
      cur_step <= active;
      pend_ptr <= next_ptr;
    end
  end

  // pointer is software-loadable only while idle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      queue_pointer <= 5'h00;
    end else if (advance) begin
      queue_pointer <= adv_ptr;
    end else if (idle && wr && PADDR == `QUEUE_POINTER_OFS) begin
      queue_pointer <= PWDATA[4:0];
    end
  end

  // timer restarts at each timer step, so limit 0 ends on the first wait cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      timer <= '0;
    end else if (is_exec) begin
      timer <= '0;
    end else if (state == ST_WAIT) begin
      timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      delay_cnt <= '0;
    end else if (state == ST_DELAY) begin
      delay_cnt <= delay_cnt + 1'b1;
    end else begin
      delay_cnt <= {{(DW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      trig_prev <= '0;
      swt_prev  <= 1'b0;
    end else begin
      trig_prev <= TRIG_IN;
      swt_prev  <= software_trigger_bit;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      step_delay_timer <= 1'b0;
    end else if (is_exec && active.op == `OP_CONTROL) begin
      if (active.opt == `CTL_SD_OFF) begin
        step_delay_timer <= 1'b0;
      end else if (active.opt == `CTL_SD_ON) begin
        step_delay_timer <= 1'b1;
      end
    end
  end

  // loop counter restarts when its loop exits, so the loop can be re-entered
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      loop_counter_0 <= '0;
      loop_counter_1 <= '0;
    end else if (is_exec && active.op[3:2] == 2'b11) begin
      if (!lp_sel) begin
        loop_counter_0 <= lp_equal ? '0 : loop_counter_0 + 1'b1;
      end else begin
        loop_counter_1 <= lp_equal ? '0 : loop_counter_1 + 1'b1;
      end
    end
  end

  // ==========================================================
  // software registers, locked while the queue runs, except hold which stays writable
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < `LIM_COUNT; i++) begin
        lim[i] <= '0;
      end
      adjust_value             <= '0;
      hold_value               <= '0;
      broadcast_trigger_enable <= '0;
    end else begin
      if (wr && PADDR == `HOLD_OFS) begin
        hold_value <= PWDATA[DW-1:0];
      end
      if (is_exec && active.op == `OP_ADD_COPY && active.opt[2:0] < 3'(`LIM_COUNT)) begin
        if (active.opt[3]) begin
          lim[active.opt[2:0]] <= hold_value;
        end else begin
          lim[active.opt[2:0]] <= lim[active.opt[2:0]] + adjust_value;
        end
      end else if (idle && wr) begin
        case (PADDR)
          `ADJUST_OFS:           adjust_value <= PWDATA[DW-1:0];
          `LOOP_LIMIT_0_OFS:     lim[`LIM_LOOP0] <= PWDATA[DW-1:0];
          `LOOP_LIMIT_1_OFS:     lim[`LIM_LOOP1] <= PWDATA[DW-1:0];
          `TIMER_LIMIT_0_OFS:    lim[`LIM_TMR0] <= PWDATA[DW-1:0];
          `TIMER_LIMIT_1_OFS:    lim[`LIM_TMR1] <= PWDATA[DW-1:0];
          `STEP_DELAY_LIMIT_OFS: lim[`LIM_SD] <= PWDATA[DW-1:0];
          `LITERAL_OFS:          lim[`LIM_LIT] <= PWDATA[DW-1:0];
          `BROADCAST_OFS:        broadcast_trigger_enable <= PWDATA[N_OUT-1:0];
          default:               adjust_value <= adjust_value;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 32; i++) begin
        queue[i] <= 8'h00;
      end
    end else if (idle && wr && PADDR[11:5] == `QUEUE_SEL) begin
      for (int b = 0; b < 4; b++) begin
        if (PSTRB[b]) begin
          queue[{PADDR[4:2], 2'(b)}] <= PWDATA[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // outputs to peripherals
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      TRIG_OUT <= '0;
      IRQ      <= '0;
    end else begin
      TRIG_OUT <= '0;
      IRQ      <= '0;
      if (is_exec) begin
        case (active.op)
          `OP_TRIG_0, `OP_TRIG_1: TRIG_OUT[target] <= 1'b1;
          `OP_IRQ: begin
            if (!active.opt[3]) begin
              IRQ[active.opt[2:0]] <= 1'b1;
            end
          end
          `OP_CONTROL: begin
            if (active.opt == `CTL_BCAST) begin
              TRIG_OUT <= broadcast_trigger_enable;
            end
          end
          default: IRQ <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      STROBE       <= '0;
      STROBE_VALID <= 1'b0;
    end else begin
      STROBE_VALID <= 1'b0;
      if (is_exec) begin
        case (active.op)
          `OP_STROBE_0, `OP_STROBE_1: begin
            STROBE       <= DW'(target);
            STROBE_VALID <= 1'b1;
          end
          `OP_CONTROL: begin
            case (active.opt)
              `CTL_STB_C0: begin
                STROBE       <= lim[`LIM_LOOP0];
                STROBE_VALID <= 1'b1;
              end
              `CTL_STB_C1: begin
                STROBE       <= lim[`LIM_LOOP1];
                STROBE_VALID <= 1'b1;
              end
              `CTL_STB_LIT: begin
                STROBE       <= lim[`LIM_LIT];
                STROBE_VALID <= 1'b1;
              end
              default: STROBE_VALID <= 1'b0;
            endcase
          end
          default: STROBE_VALID <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RUNNING <= 1'b0;
    end else begin
      RUNNING <= run && !(state == ST_IDLE && !run);
    end
  end

endmodule

// >>> dv/trigger_sequencer_step_decoder_chk.sv
`include "ptg_map.svh"
// ==========================================================
// port-level checks
module trigger_sequencer_step_decoder_chk #(
  parameter int DW    = 16,
  parameter int N_OUT = 32,
  parameter int N_IRQ = 8
) (
  input wire logic             CORE_CLK,
  input wire logic             RST_N,
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [11:0]      PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  input wire logic [N_OUT-1:0] TRIG_OUT,
  input wire logic [N_IRQ-1:0] IRQ,
  input wire logic [DW-1:0]    STROBE,
  input wire logic             STROBE_VALID,
  input wire logic             RUNNING
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  sequence s_ctrl_write;
    PREADY && PSEL && PWRITE && PADDR == `CONTROL_OFS;
  endsequence

  property p_ready_wait;
    s_access |=> s_answer;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("answer late");
  property p_setup_quiet;
    PSEL && !PENABLE |=> !PREADY;
  endproperty
  a_setup_quiet: assert property (p_setup_quiet) else $error("answer in setup");
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_ready_cause;
    PREADY |-> $past(PSEL && PENABLE);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready unasked");
  property p_run_follow;
    s_ctrl_write |-> ##2 RUNNING == $past(PWDATA[0], 2);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("run flag lost");
  property p_strobe_hold;
    !STROBE_VALID |-> STROBE == $past(STROBE);
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved");
  // one cycle of grace: a step may finish on the edge that stops the run
  property p_idle_quiet;
    !RUNNING && !$past(RUNNING) |-> TRIG_OUT == '0 && IRQ == '0 && !STROBE_VALID;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output while idle");
  property p_irq_single;
    $onehot0(IRQ);
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("several irqs");
endmodule

bind trigger_sequencer_step_decoder trigger_sequencer_step_decoder_chk #(
  .DW(DW), .N_OUT(N_OUT), .N_IRQ(N_IRQ)
) i_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRIG_OUT(TRIG_OUT), .IRQ(IRQ), .STROBE(STROBE), .STROBE_VALID(STROBE_VALID),
  .RUNNING(RUNNING)
);

// >>> dv/periph_model.sv
// ==========================================================
// peripherals: input sources with selectable lag, pulse counters
module periph_model (
  input wire logic  clk,
  input wire logic  rst_n,
  input wire logic  [1:0]  lag,
  input wire logic  [15:0] lvl,
  input wire logic  [31:0] trig_out,
  input wire logic  [7:0]  irq,
  output logic      [15:0] trig_in,
  output logic      [31:0] trig_or,
  output logic      [7:0]  irq_or,
  output int               trig_cnt,
  output int               irq_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pipe [4] = '{default: '0};
  // a slow source shows its edge a few cycles late, as a real one may
  assign trig_in = pipe[lag];
  always @(posedge clk) begin
    pipe[0] <= lvl;
    for (int k = 1; k < 4; k++) pipe[k] <= pipe[k-1];
    if (!rst_n) begin
      trig_or  <= '0;
      irq_or   <= '0;
      trig_cnt <= 0;
      irq_cnt  <= 0;
    end else begin
      trig_or <= trig_or | trig_out;
      irq_or  <= irq_or | irq;
      if (|trig_out) trig_cnt <= trig_cnt + 1;
      if (|irq) irq_cnt <= irq_cnt + 1;
    end
  end
endmodule

// >>> dv/trigger_sequencer_step_decoder_bench.sv
`include "ptg_map.svh"
module trigger_sequencer_step_decoder_bench import ptg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rq, trig_out, trig_or, seed = 32'h39f0, bte;
  logic        pready, pslverr, rerr, strobe_valid, running;
  logic [15:0] trig_in, strobe, adj, hold, lit, lvl = '0;
  logic [7:0]  irq, irq_or;
  logic [4:0]  t, st;
  logic [3:0]  s;
  logic [2:0]  i;
  logic [1:0]  lag = '0;
  int          mismatches = 0, check_count = 0, trig_cnt, irq_cnt, base;
  int          cyc = 0, dl, tl;
  int          tq [$];
  logic [15:0] sq [$];

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (strobe_valid === 1'b1) begin
      sq.push_back(strobe);
      tq.push_back(cyc);
    end
  end

  trigger_sequencer_step_decoder i_trigger_sequencer_step_decoder (
    .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TRIG_IN(trig_in), .TRIG_OUT(trig_out), .IRQ(irq),
    .STROBE(strobe), .STROBE_VALID(strobe_valid), .RUNNING(running));
  periph_model i_periph_model (
    .clk(clk), .rst_n(rst_n), .lag(lag), .lvl(lvl), .trig_out(trig_out), .irq(irq),
    .trig_in(trig_in), .trig_or(trig_or), .irq_or(irq_or), .trig_cnt(trig_cnt),
    .irq_cnt(irq_cnt));

  // ==========================================================
  // helpers
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic [7:0] enc(input logic [3:0] op, input logic [3:0] opt);
    step_t b;
    b.op = op;
    b.opt = opt;
    return b;
  endfunction
  function logic [31:0] mask(input int a);
    return (a == `BROADCAST_OFS) ? 32'hffffffff : 32'h0000ffff;
  endfunction
  task stop_test;
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin mismatches++; stop_test; end
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_irq(input int n);
    int k;
    k = 0;
    while (irq_cnt - base != n && k < 100) begin @(posedge clk); k++; end
    chk(32'(irq_cnt - base), 32'(n));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= `LOOP_COUNTER_1_OFS; a += 4) begin
      apb(0, 12'(a), 0); chk(rq, 0);
    end
    apb(0, 12'h100, 0); chk(32'(rerr), 1);
    for (int a = `ADJUST_OFS; a <= `BROADCAST_OFS; a += 4) begin
      seed = lfsr(seed);
      apb(1, 12'(a), seed);
      apb(0, 12'(a), 0); chk(rq, seed & mask(a));
    end
    apb(1, `LOOP_COUNTER_0_OFS, 5); apb(0, `LOOP_COUNTER_0_OFS, 0); chk(rq, 0);
    // arithmetic, outputs and loop 0
    seed = lfsr(seed); adj = seed[15:0]; hold = seed[31:16];
    seed = lfsr(seed); lit = seed[15:0]; bte = seed | 32'h1;
    seed = lfsr(seed); t = seed[4:0]; st = seed[9:5]; i = seed[12:10];
    apb(1, `ADJUST_OFS, adj); apb(1, `HOLD_OFS, hold); apb(1, `LITERAL_OFS, lit);
    apb(1, `BROADCAST_OFS, bte); apb(1, `LOOP_LIMIT_0_OFS, 2);
    apb(1, 12'h040, {enc(1, 4'he), enc(6, 0), enc(7, {1'b0, i}), enc({3'h4, t[4]}, t[3:0])});
    apb(1, 12'h044, {enc(0, 4'hf), enc(1, 4'hd), enc(0, 4'he), enc(1, 5)});
    apb(1, 12'h048, {enc(4'ha, 4'hb), enc(7, 8), enc({3'h1, st[4]}, st[3:0]), enc(4'hc, 7)});
    apb(1, `CONTROL_OFS, 1);
    for (int k = 0; k < 40 && rq !== 32'd11; k++) apb(0, `QUEUE_POINTER_OFS, 0);
    chk(rq, 11);
    chk(32'(trig_cnt), 4);
    chk(trig_or, (32'h1 << t) | bte);
    chk(32'(irq_or), 32'(8'h1 << i));
    chk(32'(sq.size()), 2);
    chk(32'(sq[0]), 32'(16'(lit + adj)));
    chk(32'(sq[1]), 32'(st));
    apb(0, `LITERAL_OFS, 0); chk(rq, 32'(hold));
    apb(1, `LITERAL_OFS, 0); apb(0, `LITERAL_OFS, 0); chk(rq, 32'(hold));
    apb(0, `LOOP_COUNTER_0_OFS, 0); chk(rq, 0);
    // waits, timer, software trigger and loop 1
    apb(1, `CONTROL_OFS, 0); apb(1, `QUEUE_POINTER_OFS, 0);
    seed = lfsr(seed); s = seed[3:0]; lag <= seed[5:4];
    apb(1, `TIMER_LIMIT_0_OFS, 32'(seed[8:6])); apb(1, `LOOP_LIMIT_1_OFS, 1);
    apb(1, 12'h040, {enc(7, 2), enc(5, s), enc(7, 0), enc(4, s)});
    apb(1, 12'h044, {enc(4'he, 6), enc(7, 1), enc(0, 4'hb), enc(0, 8)});
    apb(1, 12'h048, {24'h0, enc(4'ha, 8)});
    base = irq_cnt;
    apb(1, `CONTROL_OFS, 1);
    repeat (20) @(posedge clk);
    chk(32'(irq_cnt - base), 0);
    apb(0, `STATUS_OFS, 0); chk(rq, 3);
    lvl[s] <= 1'b1;
    wait_irq(1);
    repeat (20) @(posedge clk);
    chk(32'(irq_cnt - base), 1);
    lvl[s] <= 1'b0;
    wait_irq(2);
    repeat (30) @(posedge clk);
    chk(32'(irq_cnt - base), 2);
    apb(1, `CONTROL_OFS, 3);
    wait_irq(4);
    chk(32'(irq_or), 32'(8'h7 | (8'h1 << i)));
    // step delay on and off around a timer 1 wait, spacing measured between strobes
    apb(1, `CONTROL_OFS, 0); apb(1, `QUEUE_POINTER_OFS, 12);
    seed = lfsr(seed); dl = 32'(seed[2:0]) + 1; tl = 32'(seed[5:3]);
    apb(1, `STEP_DELAY_LIMIT_OFS, dl); apb(1, `TIMER_LIMIT_1_OFS, tl);
    apb(1, 12'h04c, {enc(2, 2), enc(0, 9), enc(2, 1), enc(0, 6)});
    apb(1, 12'h050, {enc(4'hb, 3), enc(2, 4), enc(2, 3), enc(0, 2)});
    sq.delete(); tq.delete();
    apb(1, `CONTROL_OFS, 1);
    for (int k = 0; k < 200 && sq.size() < 4; k++) @(posedge clk);
    chk(32'(sq.size()), 4);
    chk(32'(tq[1] - tq[0]), 32'(3 + tl + 2 * dl));
    chk(32'(tq[2] - tq[1]), 32'(2 + 2 * dl));
    chk(32'(tq[3] - tq[2]), 1);
    chk({16'h0, sq[0][3:0], sq[1][3:0], sq[2][3:0], sq[3][3:0]}, 32'h1234);
    stop_test;
  end
endmodule
